// File: drive_core_model.sv
// Power stage model: control tick, bus voltage and undervoltage flag
`timescale 1ns/10ps
module drive_core_model #(
  parameter int TICK_CYCLES = 4,
  parameter int UV_LEVEL    = 2100
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Supply level set by the bench
  input  wire logic [13:0] bus_set,
  // Toward the supervisor
  output logic             loop_tick,
  output logic [13:0]      bus_voltage,
  output logic             undervoltage
);
  int cnt;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt       <= 0;
      loop_tick <= 1'b0;
    end else begin
      cnt       <= (cnt == TICK_CYCLES - 1) ? 0 : cnt + 1;
      loop_tick <= (cnt == TICK_CYCLES - 1);
    end
  end
  // Bus follows the supply; trip level sits below every start level used
  assign bus_voltage  = bus_set;
  assign undervoltage = (bus_set < 14'(UV_LEVEL));
endmodule // drive_core_model

// File: ride_through_consts.svh
// Register offsets, reset values, limits and timing for the ride-through supervisor
`ifndef RIDE_THROUGH_CONSTS_SVH
`define RIDE_THROUGH_CONSTS_SVH
`define RT_OFF_CTRL     8'h00
`define RT_OFF_START    8'h04
`define RT_OFF_TARGET   8'h08
`define RT_OFF_DECEL    8'h0C
`define RT_OFF_STEP     8'h10
`define RT_OFF_KP       8'h14
`define RT_OFF_TI       8'h18
`define RT_OFF_TLIM     8'h1C
`define RT_OFF_MFI_LO   8'h20
`define RT_OFF_MFI_HI   8'h24
`define RT_OFF_STATUS   8'h28
`define RT_RST_START    14'h0898
`define RT_RST_TARGET   14'h0E10
`define RT_RST_DECEL    19'h0_0064
`define RT_RST_KP       8'h14
`define RT_RST_TI       16'h0064
`define RT_RST_TL       8'h96
`define RT_MAX_VOLT     14'h2710
`define RT_MAX_DECEL    19'h5_7E40
`define RT_MAX_STEP     16'h03E8
`define RT_MAX_TI       16'hFFFA
`define RT_TL_MAX_SMALL 8'hC8
`define RT_TL_MAX_LARGE 8'hB4
`define RT_FN_TL_EN     8'h28
`define RT_FN_TL_SW1    8'h29
`define RT_FN_TL_SW2    8'h2A
`define RT_DECEL_UNIT_MS 10
`define RT_TICK_MS       1
`define RT_TICKS_PER_UNIT (`RT_DECEL_UNIT_MS / `RT_TICK_MS)
`define RT_KP_SHIFT     7
`endif

// File: ride_through_decel_control.sv
// Ride-through deceleration supervisor with torque ramp hold and AXI4-Lite registers
//
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/10ps
`include "ride_through_consts.svh"
module ride_through_decel_control #(
  parameter bit LARGE_UNIT = 1'b0
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Pins
  input  wire logic        forward_run_command,
  input  wire logic        mains_present,
  input  wire logic        control_power_dip,
  input  wire logic [7:0]  input_terminals,
  // Drive core, same clock
  input  wire logic        loop_tick,
  input  wire logic [13:0] bus_voltage,
  input  wire logic        undervoltage,
  input  wire logic        tripped,
  input  wire logic        torque_limiting,
  input  wire logic [15:0] frequency_ref,
  input  wire logic        quadrant_reverse,
  input  wire logic        quadrant_regen,
  input  wire logic [7:0]  analog_torque_limit,
  input  wire logic [7:0]  option_torque_limit,
  // Power stage
  output logic [15:0]      out_freq_reg,
  output logic             ramp_hold_reg,
  output logic             output_shutoff_reg,
  output logic [7:0]       torque_limit_reg,
  output logic             ride_active_reg
);
  ride_through_pkg::rt_state_t st_reg;
  logic [10:0] sync1_reg;
  logic [10:0] sync2_reg;
  logic [1:0]  mode_reg;
  logic        hold_sel_reg;
  logic [2:0]  method_reg;
  logic [2:0]  tl_src_reg;
  logic [13:0] start_v_reg;
  logic [13:0] target_v_reg;
  logic [18:0] decel_reg;
  logic [15:0] step_reg;
  logic [7:0]  kp_reg;
  logic [15:0] ti_reg;
  logic [31:0] tlim_reg;
  logic [63:0] mfi_reg;
  logic [22:0] dda_reg;
  logic [15:0] fstart_reg;
  logic [15:0] icnt_reg;
  logic signed [23:0] integ_reg;
  logic        aw_have_reg;
  logic        w_have_reg;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  // Synchronised pins
  wire run_s   = sync2_reg[0];
  wire mains_s = sync2_reg[1];
  wire dip_s   = sync2_reg[2];
  wire [7:0] term_s = sync2_reg[10:3];
  // Input function decode
  logic [7:0] is_en;
  logic [7:0] is_sw1;
  logic [7:0] is_sw2;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_fn
      assign is_en[gi]  = mfi_reg[gi*8 +: 8] == `RT_FN_TL_EN;
      assign is_sw1[gi] = mfi_reg[gi*8 +: 8] == `RT_FN_TL_SW1;
      assign is_sw2[gi] = mfi_reg[gi*8 +: 8] == `RT_FN_TL_SW2;
    end
  endgenerate
  wire en_assigned = |is_en;
  wire en_on       = |(is_en & term_s);
  wire sw1_on      = |(is_sw1 & term_s);
  wire sw2_on      = |(is_sw2 & term_s);
  // Torque limit selection
  wire [7:0] tl_max = LARGE_UNIT ? `RT_TL_MAX_LARGE : `RT_TL_MAX_SMALL;
  wire [1:0] quad_idx = {quadrant_reverse ^ quadrant_regen, quadrant_regen};
  wire [1:0] term_idx = {sw2_on, sw1_on};
  logic [7:0] tl_sel;
  always_comb begin
    case (ride_through_pkg::tl_source_t'(tl_src_reg))
      ride_through_pkg::tl_quadrant: tl_sel = tlim_reg[quad_idx*8 +: 8];
      ride_through_pkg::tl_terminal: tl_sel = tlim_reg[term_idx*8 +: 8];
      ride_through_pkg::tl_analog:   tl_sel = analog_torque_limit;
      default:                       tl_sel = option_torque_limit;
    endcase
  end
  wire [7:0] tl_lim  = (tl_sel > tl_max) ? tl_max : tl_sel;
  wire [7:0] tl_next = (en_assigned && !en_on) ? tl_max : tl_lim;
  // Thresholds and ramp hold
  wire vector_mode = method_reg >= 3'd3 && method_reg <= 3'd5;
  wire hold_now    = hold_sel_reg && vector_mode && torque_limiting;
  wire [13:0] eff_level = (target_v_reg < start_v_reg) ? start_v_reg : target_v_reg;
  wire below_start = bus_voltage < start_v_reg;
  wire over_level  = bus_voltage >= eff_level;
  wire running     = run_s && !tripped && !undervoltage && out_freq_reg != 16'h0000;
  wire go_decel = loop_tick && running && mode_reg == 2'(ride_through_pkg::rt_decel_stop)
                  && below_start;
  wire go_dcc   = loop_tick && running && mode_reg[1] && (dip_s || below_start);
  wire in_fn    = st_reg == ride_through_pkg::st_decel || st_reg == ride_through_pkg::st_dcc;
  wire [15:0] stepped = (out_freq_reg > step_reg) ? out_freq_reg - step_reg : 16'h0000;
  // Timed deceleration
  wire [22:0] decel_ticks = 23'(decel_reg) * 23'(`RT_TICKS_PER_UNIT);
  wire [22:0] dda_sum     = dda_reg + 23'(fstart_reg);
  wire        dda_hit     = dda_sum >= decel_ticks;
  wire [15:0] dec_one     = (out_freq_reg != 16'h0000) ? out_freq_reg - 16'h0001 : 16'h0000;
  // PI bus regulation
  wire signed [14:0] err   = $signed({1'b0, eff_level}) - $signed({1'b0, bus_voltage});
  wire signed [23:0] p_raw = $signed({1'b0, kp_reg}) * err;
  wire signed [23:0] delta = (p_raw >>> `RT_KP_SHIFT) + integ_reg;
  wire        i_due   = icnt_reg >= ti_reg;
  wire [15:0] d_mag   = (delta > 24'sd65535) ? 16'hFFFF : delta[15:0];
  wire [15:0] pi_freq = (delta <= 0) ? out_freq_reg :
                        (d_mag > out_freq_reg) ? 16'h0000 : out_freq_reg - d_mag;
  // Normal ramp
  wire [15:0] tgt_f   = run_s ? frequency_ref : 16'h0000;
  wire [15:0] norm_f  = (out_freq_reg < tgt_f) ? out_freq_reg + 16'h0001 :
                        (out_freq_reg > tgt_f && !hold_now) ? dec_one : out_freq_reg;
  // State and ramp update
  ride_through_pkg::rt_state_t st_next;
  logic [15:0] f_next;
  always_comb begin
    st_next = st_reg;
    f_next  = out_freq_reg;
    case (st_reg)
      ride_through_pkg::st_normal: begin
        if (go_dcc) begin
          st_next = ride_through_pkg::st_dcc;
        end else if (go_decel) begin
          st_next = ride_through_pkg::st_decel;
          f_next  = stepped;
        end else if (loop_tick) begin
          f_next = norm_f;
        end
      end
      ride_through_pkg::st_decel: begin
        if (undervoltage) begin
          st_next = ride_through_pkg::st_shutoff;
          f_next  = 16'h0000;
        end else if (out_freq_reg == 16'h0000) begin
          st_next = ride_through_pkg::st_stopped;
        end else if (loop_tick && !over_level && dda_hit) begin
          f_next = dec_one;
        end
      end
      ride_through_pkg::st_dcc: begin
        if (undervoltage) begin
          st_next = ride_through_pkg::st_shutoff;
          f_next  = 16'h0000;
        end else if (out_freq_reg == 16'h0000) begin
          st_next = ride_through_pkg::st_stopped;
        end else if (loop_tick && mains_s && !dip_s && !(eff_level > bus_voltage)) begin
          st_next = mode_reg[0] ? ride_through_pkg::st_normal
                                : ride_through_pkg::st_decel;
        end else if (loop_tick) begin
          f_next = pi_freq;
        end
      end
      ride_through_pkg::st_stopped: begin
        f_next = 16'h0000;
        if (!run_s) begin
          st_next = ride_through_pkg::st_normal;
        end
      end
      ride_through_pkg::st_shutoff: begin
        f_next = 16'h0000;
        if (!run_s) begin
          st_next = ride_through_pkg::st_normal;
        end
      end
      default: st_next = ride_through_pkg::st_normal;
    endcase
  end
  wire shut_next = st_next == ride_through_pkg::st_shutoff;
  wire hold_next = (st_reg == ride_through_pkg::st_normal && hold_now) ||
                   (st_reg == ride_through_pkg::st_decel && over_level);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= 11'h000;
      sync2_reg <= 11'h000;
    end else begin
      sync1_reg <= {input_terminals, control_power_dip, mains_present, forward_run_command};
      sync2_reg <= sync1_reg;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg             <= ride_through_pkg::st_normal;
      out_freq_reg       <= 16'h0000;
      ramp_hold_reg      <= 1'b0;
      output_shutoff_reg <= 1'b0;
      torque_limit_reg   <= 8'h00;
      ride_active_reg    <= 1'b0;
    end else begin
      st_reg             <= st_next;
      out_freq_reg       <= f_next;
      ramp_hold_reg      <= hold_next;
      output_shutoff_reg <= shut_next;
      torque_limit_reg   <= tl_next;
      ride_active_reg    <= st_next != ride_through_pkg::st_normal;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || !in_fn) begin
      dda_reg    <= 23'h00_0000;
      fstart_reg <= f_next;
      icnt_reg   <= 16'h0000;
      integ_reg  <= 24'sd0;
    end else if (loop_tick) begin
      dda_reg   <= (st_reg == ride_through_pkg::st_decel && !over_level) ?
                   (dda_hit ? dda_sum - decel_ticks : dda_sum) : dda_reg;
      icnt_reg  <= i_due ? 16'h0000 : icnt_reg + 16'h0001;
      integ_reg <= i_due ? integ_reg + 24'(err) : integ_reg;
    end
  end
  // Register bus
  function automatic logic [31:0] reg_read(input logic [7:0] a);
    case (a)
      `RT_OFF_CTRL:   reg_read = {17'h0, tl_src_reg, 1'b0, method_reg, 3'h0, hold_sel_reg,
                                  2'h0, mode_reg};
      `RT_OFF_START:  reg_read = {18'h0, start_v_reg};
      `RT_OFF_TARGET: reg_read = {18'h0, target_v_reg};
      `RT_OFF_DECEL:  reg_read = {13'h0, decel_reg};
      `RT_OFF_STEP:   reg_read = {16'h0, step_reg};
      `RT_OFF_KP:     reg_read = {24'h0, kp_reg};
      `RT_OFF_TI:     reg_read = {16'h0, ti_reg};
      `RT_OFF_TLIM:   reg_read = tlim_reg;
      `RT_OFF_MFI_LO: reg_read = mfi_reg[31:0];
      `RT_OFF_MFI_HI: reg_read = mfi_reg[63:32];
      `RT_OFF_STATUS: reg_read = {out_freq_reg, torque_limit_reg, 3'h0, output_shutoff_reg,
                                  ramp_hold_reg, 3'(st_reg)};
      default:        reg_read = 32'h0000_0000;
    endcase
  endfunction
  function automatic logic [13:0] clamp_v(input logic [31:0] d);
    clamp_v = (d > 32'(`RT_MAX_VOLT)) ? `RT_MAX_VOLT : d[13:0];
  endfunction
  wire        mapped_w = awaddr_reg <= `RT_OFF_MFI_HI && awaddr_reg[1:0] == 2'b00;
  wire        mapped_r = s_axi_araddr <= `RT_OFF_STATUS && s_axi_araddr[1:0] == 2'b00;
  wire [31:0] bmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}},
                       {8{wstrb_reg[0]}}};
  wire [31:0] wd = (reg_read(awaddr_reg) & ~bmask) | (wdata_reg & bmask);
  wire        do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;
  wire [7:0]  tl_w [4];
  generate
    for (gi = 0; gi < 4; gi++) begin : g_tl
      assign tl_w[gi] = (wd[gi*8 +: 8] > tl_max) ? tl_max : wd[gi*8 +: 8];
    end
  endgenerate
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped_w ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  always_comb begin
    s_axi_awready = !aw_have_reg && aresetn;
    s_axi_wready  = !w_have_reg && aresetn;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg     <= 2'(ride_through_pkg::rt_off);
      hold_sel_reg <= 1'b0;
      method_reg   <= 3'h0;
      tl_src_reg   <= 3'(ride_through_pkg::tl_quadrant);
      start_v_reg  <= `RT_RST_START;
      target_v_reg <= `RT_RST_TARGET;
      decel_reg    <= `RT_RST_DECEL;
      step_reg     <= 16'h0000;
      kp_reg       <= `RT_RST_KP;
      ti_reg       <= `RT_RST_TI;
      tlim_reg     <= {4{`RT_RST_TL}};
      mfi_reg      <= 64'h0;
    end else if (do_write) begin
      case (awaddr_reg)
        `RT_OFF_CTRL: begin
          mode_reg     <= wd[1:0];
          hold_sel_reg <= wd[4];
          method_reg   <= wd[10:8];
          tl_src_reg   <= (wd[14:12] > 3'd4) ? tl_src_reg : wd[14:12];
        end
        `RT_OFF_START:  start_v_reg  <= clamp_v(wd);
        `RT_OFF_TARGET: target_v_reg <= clamp_v(wd);
        `RT_OFF_DECEL:  decel_reg <= (wd == 32'h0) ? 19'h0_0001 :
                          (wd > 32'(`RT_MAX_DECEL)) ? `RT_MAX_DECEL : wd[18:0];
        `RT_OFF_STEP:   step_reg <= (wd > 32'(`RT_MAX_STEP)) ? `RT_MAX_STEP : wd[15:0];
        `RT_OFF_KP:     kp_reg <= wd[7:0];
        `RT_OFF_TI:     ti_reg <= (wd > 32'(`RT_MAX_TI)) ? `RT_MAX_TI : wd[15:0];
        `RT_OFF_TLIM:   tlim_reg <= {tl_w[3], tl_w[2], tl_w[1], tl_w[0]};
        `RT_OFF_MFI_LO: mfi_reg[31:0] <= wd;
        `RT_OFF_MFI_HI: mfi_reg[63:32] <= wd;
        default: ;
      endcase
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= reg_read(s_axi_araddr);
        s_axi_rresp  <= mapped_r ? 2'b00 : 2'b10;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence enter_dcc_s;
    st_reg != ride_through_pkg::st_dcc ##1 st_reg == ride_through_pkg::st_dcc;
  endsequence
  hold_torque_a: assert property (st_reg == ride_through_pkg::st_normal && loop_tick
      && hold_now && out_freq_reg > tgt_f |=> out_freq_reg == $past(out_freq_reg))
    else $error("ramp moved down during torque hold");
  tl_gate_a: assert property (en_assigned && !en_on |=> torque_limit_reg == tl_max)
    else $error("torque limit not maximum with gate off");
  dcc_start_a: assert property (enter_dcc_s |-> $past(mode_reg[1]) && $past(run_s))
    else $error("constant control started wrongly");
  uv_shut_a: assert property (in_fn && undervoltage |=> output_shutoff_reg
      && out_freq_reg == 16'h0000) else $error("no shutoff on undervoltage");
  ov_hold_a: assert property (st_reg == ride_through_pkg::st_decel && loop_tick
      && over_level && !undervoltage && out_freq_reg != 16'h0000 |=> $stable(out_freq_reg))
    else $error("ramp moved above stop level");
  entry_step_a: assert property (st_reg == ride_through_pkg::st_normal && go_decel
      && !go_dcc |=> out_freq_reg == $past(stepped)) else $error("initial step wrong");
  stop_latch_a: assert property (st_reg == ride_through_pkg::st_stopped && run_s
      |=> st_reg == ride_through_pkg::st_stopped) else $error("restart without run off");
  eff_level_a: assert property (st_reg == ride_through_pkg::st_decel
      && target_v_reg < start_v_reg && bus_voltage >= start_v_reg |=> ramp_hold_reg)
    else $error("stop level not raised to start");
endmodule // ride_through_decel_control

// File: ride_through_pkg.sv
// Types shared by the ride-through supervisor
package ride_through_pkg;
  typedef enum logic [1:0] {rt_off, rt_decel_stop, rt_dc_norecover, rt_dc_recover} rt_mode_t;
  typedef enum logic [2:0] {tl_quadrant, tl_terminal, tl_analog, tl_option1, tl_option2}
    tl_source_t;
  typedef enum {st_normal, st_decel, st_dcc, st_stopped, st_shutoff} rt_state_t;
endpackage

// File: test_ride_through_decel_control.sv
// Self-checking bench for the ride-through supervisor
`timescale 1ns/10ps
`include "ride_through_consts.svh"
module test_ride_through_decel_control;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, tick, uv;
  logic        run, dip, tl_act, hold, shutoff, active;
  logic [7:0]  awaddr, araddr, terms, alim, olim, tlim;
  logic [31:0] wdata, rdata, d32;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r2;
  logic [13:0] bus_set, bus_v;
  logic [15:0] fref, fout;
  logic [31:0] mdl [logic [7:0]];
  int          mismatches, checked, seed, ref_f, f;
  int          meths[4] = '{5, 4, 3, 0};
  int          dmodes[3] = '{0, 2, 3};
  int          quad_lim[4] = '{1, 3, 4, 2};

  ride_through_decel_control u_ride_through_decel_control (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .forward_run_command(run), .mains_present(1'b1), .control_power_dip(dip),
    .input_terminals(terms), .loop_tick(tick), .bus_voltage(bus_v), .undervoltage(uv),
    .tripped(1'b0), .torque_limiting(tl_act), .frequency_ref(fref),
    .quadrant_reverse(terms[6]), .quadrant_regen(terms[7]),
    .analog_torque_limit(alim), .option_torque_limit(olim),
    .out_freq_reg(fout), .ramp_hold_reg(hold), .output_shutoff_reg(shutoff),
    .torque_limit_reg(tlim), .ride_active_reg(active)
  );
  drive_core_model u_drive_core_model (
    .aclk(aclk), .aresetn(aresetn), .bus_set(bus_set),
    .loop_tick(tick), .bus_voltage(bus_v), .undervoltage(uv)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic int rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] model_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    v = d;
    case (a)
      `RT_OFF_START, `RT_OFF_TARGET: if (d > `RT_MAX_VOLT) v = `RT_MAX_VOLT;
      `RT_OFF_DECEL: if (d > `RT_MAX_DECEL) v = `RT_MAX_DECEL;
      `RT_OFF_STEP: if (d > `RT_MAX_STEP) v = `RT_MAX_STEP;
      `RT_OFF_TLIM: for (int i = 0; i < 4; i++) begin
        if (d[8*i+:8] > `RT_TL_MAX_SMALL) v[8*i+:8] = `RT_TL_MAX_SMALL;
      end
      default: ;
    endcase
    return v;
  endfunction
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'b111;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    bready <= 1'b0;
    r = bresp;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axw(a, d, r);
    chk(r, 2'b00);
    mdl[a] = model_wr(a, d);
  endtask
  task automatic rd_chk(input logic [7:0] a);
    logic [31:0] d;
    logic [1:0]  r;
    axr(a, d, r);
    chk({r, d[29:0]}, {2'b00, mdl[a][29:0]});
    chk(d[31:30], mdl[a][31:30]);
  endtask
  task automatic wait_for(input logic [16:0] m, input logic [16:0] v);
    int n;
    n = 0;
    while ((({active, fout} & m) !== v) && n < 2000) begin
      @(posedge aclk);
      n++;
    end
    chk({active, fout} & m, v);
  endtask
  task automatic spin();
    ref_f = 40 + (rnd() & 31);
    run <= 1'b1;
    fref <= 16'(ref_f);
    wait_for(17'h0_FFFF, 17'(ref_f));
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // Whole run needs some 2000 cycles
  initial begin
    repeat (40000) @(posedge aclk);
    mismatches++;
    report_and_stop();
  end
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, run, dip, tl_act} = '0;
    {awaddr, araddr, terms, alim, olim, fref} = '0;
    wdata = '0;
    wstrb = 4'hF;
    bus_set = 14'h0BB8;
    {mismatches, checked, seed} = {32'h0, 32'h0, 32'h0000_0B6C};
    mdl[`RT_OFF_CTRL] = '0;
    mdl[`RT_OFF_START] = `RT_RST_START;
    mdl[`RT_OFF_TARGET] = `RT_RST_TARGET;
    mdl[`RT_OFF_DECEL] = `RT_RST_DECEL;
    mdl[`RT_OFF_STEP] = '0;
    mdl[`RT_OFF_KP] = `RT_RST_KP;
    mdl[`RT_OFF_TI] = `RT_RST_TI;
    mdl[`RT_OFF_TLIM] = {4{`RT_RST_TL}};
    aresetn = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    foreach (mdl[a]) rd_chk(a);
    wr(`RT_OFF_START, 32'h0000_3000);
    wr(`RT_OFF_DECEL, 32'h0006_0000);
    wr(`RT_OFF_STEP, 32'h0000_07D0);
    wr(`RT_OFF_TLIM, 32'hC900_FF10);
    foreach (mdl[a]) rd_chk(a);
    axw(8'h2C, 32'h0000_0001, r2);
    chk(r2, 2'b10);
    axr(8'h2C, d32, r2);
    chk({r2, d32[29:0]}, 32'h8000_0000);
    wr(`RT_OFF_START, 32'h0000_0898);
    wr(`RT_OFF_TARGET, 32'h0000_0064);
    wr(`RT_OFF_STEP, 32'h0000_000A);
    wr(`RT_OFF_DECEL, 32'h0000_0001);
    wr(`RT_OFF_TLIM, 32'h0403_0201);
    wr(`RT_OFF_MFI_LO, 32'h2A29_0028);
    wr(`RT_OFF_MFI_HI, 32'h0000_0000);
    $display("test registers finished");
    alim <= 8'($unsigned(rnd()) % 200);
    olim <= 8'($unsigned(rnd()) % 200);
    for (int s = 0; s < 5; s++) begin
      wr(`RT_OFF_CTRL, 32'(s) << 12);
      for (int k = 0; k < 4; k++) begin
        terms <= 8'(k << 2) | 8'(k << 6) | 8'h01;
        repeat (6) @(posedge aclk);
        chk(tlim, s == 0 ? quad_lim[k] : s == 1 ? k + 1 : s == 2 ? alim : olim);
      end
    end
    terms <= 8'h00;
    repeat (6) @(posedge aclk);
    chk(tlim, `RT_TL_MAX_SMALL);
    $display("test torque limit finished");
    wr(`RT_OFF_CTRL, 32'h0000_0010);
    spin();
    fref <= 16'h0000;
    tl_act <= 1'b1;
    foreach (meths[i]) begin
      wr(`RT_OFF_CTRL, (32'(meths[i]) << 8) | 32'h0000_0010);
      repeat (12) @(posedge aclk);
      f = fout;
      repeat (12) @(posedge aclk);
      chk({hold, fout == f}, {2{meths[i] >= 3}});
    end
    tl_act <= 1'b0;
    $display("test torque ramp hold finished");
    wr(`RT_OFF_CTRL, 32'h0000_0001);
    spin();
    bus_set <= 14'h0897;
    wait_for(17'h1_0000, 17'h1_0000);
    chk(fout, ref_f - 10);
    run <= 1'b0;
    fref <= 16'h0FFF;
    repeat (12) @(posedge aclk);
    chk({active, fout < ref_f - 10, hold}, 3'b110);
    run <= 1'b1;
    bus_set <= 14'h0898;
    repeat (8) @(posedge aclk);
    f = fout;
    repeat (16) @(posedge aclk);
    chk({hold, fout == f}, 2'b11);
    bus_set <= 14'h0897;
    wait_for(17'h0_FFFF, 17'h0_0000);
    repeat (40) @(posedge aclk);
    chk({active, fout}, 17'h1_0000);
    run <= 1'b0;
    repeat (10) @(posedge aclk);
    chk(active, 1'b0);
    bus_set <= 14'h0BB8;
    spin();
    bus_set <= 14'h0866;
    wait_for(17'h1_0000, 17'h1_0000);
    bus_set <= 14'h07D0;
    repeat (3) @(posedge aclk);
    chk(shutoff, 1'b1);
    run <= 1'b0;
    bus_set <= 14'h0BB8;
    wait_for(17'h1_0000, 17'h0_0000);
    $display("test decel stop finished");
    foreach (dmodes[i]) begin
      wr(`RT_OFF_CTRL, 32'(dmodes[i]));
      spin();
      dip <= 1'b1;
      repeat (30) @(posedge aclk);
      chk(active, dmodes[i] >= 2);
      dip <= 1'b0;
      repeat (30) @(posedge aclk);
      chk(active, dmodes[i] == 2);
      if (dmodes[i] == 2) bus_set <= 14'h0866;
      run <= 1'b0;
      wait_for(17'h1_0000, 17'h0_0000);
      bus_set <= 14'h0BB8;
    end
    $display("test constant voltage finished");
    report_and_stop();
  end
endmodule // test_ride_through_decel_control
